/* core/ppfs_top.sv */
// module: port and alternate-function pin select with wishbone register slave
`timescale 1ns/1ps
module ppfs_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ppfs_pkg::ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // bidirectional port pins
  input wire logic [ppfs_pkg::BIDIR_W-1:0] bidir_pin_in,
  output logic [ppfs_pkg::BIDIR_W-1:0] bidir_pin_out,
  output logic [ppfs_pkg::BIDIR_W-1:0] bidir_pin_oe_n_out,
  output logic [ppfs_pkg::BIDIR_W-1:0] bidir_pullup_out,
  // input-only port pins
  input wire logic [ppfs_pkg::INPUT_W-1:0] input_pin_in,
  output logic [ppfs_pkg::INPUT_W-1:0] input_pull_en_out,
  output logic input_pull_down_out,
  // port 0 pins (serial and buzzer)
  input wire logic [ppfs_pkg::PORT0_W-1:0] port0_pin_in,
  output logic [ppfs_pkg::PORT0_W-1:0] port0_pin_out,
  output logic [ppfs_pkg::PORT0_W-1:0] port0_pin_oe_n_out,
  output logic [ppfs_pkg::PORT0_W-1:0] port0_pullup_out,
  // port 1 pins (carrier and timers)
  input wire logic [ppfs_pkg::PORT1_W-1:0] port1_pin_in,
  output logic [ppfs_pkg::PORT1_W-1:0] port1_pin_out,
  output logic [ppfs_pkg::PORT1_W-1:0] port1_pin_oe_n_out,
  output logic [ppfs_pkg::PORT1_W-1:0] port1_pullup_out,
  // serial channel 0 engine side
  input wire logic ser0_tx_in,
  input wire logic ser0_clk_in,
  output logic ser0_rx_out,
  output logic ser0_clk_out,
  output logic ser0_uart_mode_out,
  // serial channel 1 engine side
  input wire logic ser1_tx_in,
  input wire logic ser1_clk_in,
  output logic ser1_rx_out,
  output logic ser1_clk_out,
  // timer, carrier and buzzer engine side
  input wire logic timer2_out_in,
  input wire logic timer3_out_in,
  output logic timer2_evt_out,
  output logic timer3_evt_out,
  input wire logic carrier_in,
  output logic carrier_en_out,
  input wire logic buzzer_in,
  output logic [ppfs_pkg::BUZ_FREQ_W-1:0] buzzer_freq_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] p8_out_ff;
  logic [7:0] port_eight_direction_ff;
  logic [7:0] port_eight_pullup_ff;
  logic [8:0] input_port_pull_select_ff;
  logic [7:0] p0_out_ff;
  logic [7:0] port_zero_direction_ff;
  logic [7:0] port_zero_pullup_ff;
  logic [7:0] p0_open_drain_ff;
  logic [7:0] p1_out_ff;
  logic [7:0] port_one_direction_ff;
  logic [7:0] port_one_pullup_ff;
  logic [7:0] port_one_output_select_ff;
  logic [3:0] serial0_mode_reg3_ff;
  logic [3:0] serial1_mode_reg1_ff;
  logic carrier_output_control_ff;
  logic [3:0] delay_buzzer_control_ff;
  logic ack_ff;
  logic [31:0] dat_ff;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // byte-lane merge of a write into an 8-bit register in lane 0
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel, input logic [31:0] d);
    lane0 = sel[0] ? d[7:0] : old;
  endfunction : lane0

  // port read: latch for outputs, sampled pin for inputs
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch, input logic [7:0] pin);
    port_read = (dir & latch) | (~dir & pin);
  endfunction : port_read

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  ppfs_sync_if #(.W(ppfs_pkg::SYNC_W)) sync_bus ();

  ppfs_pin_sync #(.W(ppfs_pkg::SYNC_W)) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sync_io(sync_bus.filt)
  );

  assign sync_bus.raw = {port1_pin_in, port0_pin_in, input_pin_in, bidir_pin_in};

  wire [7:0] p8_pin = sync_bus.clean[7:0];
  wire [7:0] pa_pin = sync_bus.clean[15:8];
  wire [7:0] p0_pin = {1'b0, sync_bus.clean[22:16]};
  wire [7:0] p1_pin = sync_bus.clean[30:23];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_in & wb_stb_in & ~ack_ff;
  wire wr = req & wb_we_in;
  wire [7:0] adr = wb_adr_in;
  wire wr_p8_out = wr & (adr == ppfs_pkg::OFS_P8_OUT);
  wire wr_p8_dir = wr & (adr == ppfs_pkg::OFS_P8_DIR);
  wire wr_p8_plu = wr & (adr == ppfs_pkg::OFS_P8_PLU);
  wire wr_pa_pull = wr & (adr == ppfs_pkg::OFS_PA_PULL);
  wire wr_p0_out = wr & (adr == ppfs_pkg::OFS_P0_OUT);
  wire wr_p0_dir = wr & (adr == ppfs_pkg::OFS_P0_DIR);
  wire wr_p0_plu = wr & (adr == ppfs_pkg::OFS_P0_PLU);
  wire wr_p0_odr = wr & (adr == ppfs_pkg::OFS_P0_ODR);
  wire wr_p1_out = wr & (adr == ppfs_pkg::OFS_P1_OUT);
  wire wr_p1_dir = wr & (adr == ppfs_pkg::OFS_P1_DIR);
  wire wr_p1_plu = wr & (adr == ppfs_pkg::OFS_P1_PLU);
  wire wr_p1_omd = wr & (adr == ppfs_pkg::OFS_P1_OMD);
  wire wr_ser0 = wr & (adr == ppfs_pkg::OFS_SER0_MD3);
  wire wr_ser1 = wr & (adr == ppfs_pkg::OFS_SER1_MD1);
  wire wr_car = wr & (adr == ppfs_pkg::OFS_CARRIER);
  wire wr_buz = wr & (adr == ppfs_pkg::OFS_BUZZER);

  // single polarity bit for the whole input port, so mixing cannot be expressed
  wire [8:0] nxt_pa_pull = {
    wb_sel_in[1] ? wb_dat_in[ppfs_pkg::PA_POL_BIT] : input_port_pull_select_ff[ppfs_pkg::PA_POL_BIT],
    lane0(input_port_pull_select_ff[7:0], wb_sel_in, wb_dat_in)};

  // read mux; unmapped addresses read zero and still acknowledge
  logic [31:0] nxt_dat;
  always_comb begin
    nxt_dat = 32'h0000_0000;
    case (adr)
      ppfs_pkg::OFS_P8_OUT: nxt_dat[7:0] = p8_out_ff;
      ppfs_pkg::OFS_P8_DIR: nxt_dat[7:0] = port_eight_direction_ff;
      ppfs_pkg::OFS_P8_PLU: nxt_dat[7:0] = port_eight_pullup_ff;
      ppfs_pkg::OFS_P8_PIN: nxt_dat[7:0] = port_read(port_eight_direction_ff, p8_out_ff, p8_pin);
      ppfs_pkg::OFS_PA_PULL: nxt_dat[8:0] = input_port_pull_select_ff;
      ppfs_pkg::OFS_PA_PIN: nxt_dat[7:0] = pa_pin;
      ppfs_pkg::OFS_P0_OUT: nxt_dat[6:0] = p0_out_ff[6:0];
      ppfs_pkg::OFS_P0_DIR: nxt_dat[6:0] = port_zero_direction_ff[6:0];
      ppfs_pkg::OFS_P0_PLU: nxt_dat[6:0] = port_zero_pullup_ff[6:0];
      ppfs_pkg::OFS_P0_ODR: nxt_dat[6:0] = p0_open_drain_ff[6:0];
      ppfs_pkg::OFS_P0_PIN: nxt_dat[7:0] = port_read(port_zero_direction_ff, p0_out_ff, p0_pin);
      ppfs_pkg::OFS_P1_OUT: nxt_dat[7:0] = p1_out_ff;
      ppfs_pkg::OFS_P1_DIR: nxt_dat[7:0] = port_one_direction_ff;
      ppfs_pkg::OFS_P1_PLU: nxt_dat[7:0] = port_one_pullup_ff;
      ppfs_pkg::OFS_P1_OMD: nxt_dat[7:0] = port_one_output_select_ff;
      ppfs_pkg::OFS_P1_PIN: nxt_dat[7:0] = port_read(port_one_direction_ff, p1_out_ff, p1_pin);
      ppfs_pkg::OFS_SER0_MD3: nxt_dat[3:0] = serial0_mode_reg3_ff;
      ppfs_pkg::OFS_SER1_MD1: nxt_dat[3:0] = serial1_mode_reg1_ff;
      ppfs_pkg::OFS_CARRIER: nxt_dat[0] = carrier_output_control_ff;
      ppfs_pkg::OFS_BUZZER: nxt_dat[3:0] = delay_buzzer_control_ff;
      default: nxt_dat = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      p8_out_ff <= ppfs_pkg::RST_BYTE;
      port_eight_direction_ff <= ppfs_pkg::RST_BYTE;
      port_eight_pullup_ff <= ppfs_pkg::RST_BYTE;
      input_port_pull_select_ff <= ppfs_pkg::RST_PA_PULL;
      p0_out_ff <= ppfs_pkg::RST_BYTE;
      port_zero_direction_ff <= ppfs_pkg::RST_BYTE;
      port_zero_pullup_ff <= ppfs_pkg::RST_BYTE;
      p0_open_drain_ff <= ppfs_pkg::RST_BYTE;
      p1_out_ff <= ppfs_pkg::RST_BYTE;
      port_one_direction_ff <= ppfs_pkg::RST_BYTE;
      port_one_pullup_ff <= ppfs_pkg::RST_BYTE;
      port_one_output_select_ff <= ppfs_pkg::RST_BYTE;
      serial0_mode_reg3_ff <= ppfs_pkg::RST_SER;
      serial1_mode_reg1_ff <= ppfs_pkg::RST_SER;
      carrier_output_control_ff <= 1'b0;
      delay_buzzer_control_ff <= ppfs_pkg::RST_BUZ;
    end else begin
      if (wr_p8_out) begin
        p8_out_ff <= lane0(p8_out_ff, wb_sel_in, wb_dat_in);
      end
      if (wr_p8_dir) begin
        port_eight_direction_ff <= lane0(port_eight_direction_ff, wb_sel_in, wb_dat_in);
      end
      if (wr_p8_plu) begin
        port_eight_pullup_ff <= lane0(port_eight_pullup_ff, wb_sel_in, wb_dat_in);
      end
      if (wr_pa_pull) begin
        input_port_pull_select_ff <= nxt_pa_pull;
      end
      if (wr_p0_out) begin
        p0_out_ff <= lane0(p0_out_ff, wb_sel_in, wb_dat_in) & 8'h7f;
      end
      if (wr_p0_dir) begin
        port_zero_direction_ff <= lane0(port_zero_direction_ff, wb_sel_in, wb_dat_in) & 8'h7f;
      end
      if (wr_p0_plu) begin
        port_zero_pullup_ff <= lane0(port_zero_pullup_ff, wb_sel_in, wb_dat_in) & 8'h7f;
      end
      if (wr_p0_odr) begin
        p0_open_drain_ff <= lane0(p0_open_drain_ff, wb_sel_in, wb_dat_in) & 8'h7f;
      end
      if (wr_p1_out) begin
        p1_out_ff <= lane0(p1_out_ff, wb_sel_in, wb_dat_in);
      end
      if (wr_p1_dir) begin
        port_one_direction_ff <= lane0(port_one_direction_ff, wb_sel_in, wb_dat_in);
      end
      if (wr_p1_plu) begin
        port_one_pullup_ff <= lane0(port_one_pullup_ff, wb_sel_in, wb_dat_in);
      end
      if (wr_p1_omd) begin
        port_one_output_select_ff <= lane0(port_one_output_select_ff, wb_sel_in, wb_dat_in);
      end
      if (wr_ser0 && wb_sel_in[0]) begin
        serial0_mode_reg3_ff <= wb_dat_in[3:0];
      end
      if (wr_ser1 && wb_sel_in[0]) begin
        serial1_mode_reg1_ff <= wb_dat_in[3:0];
      end
      if (wr_car && wb_sel_in[0]) begin
        carrier_output_control_ff <= wb_dat_in[ppfs_pkg::CAR_EN_BIT];
      end
      if (wr_buz && wb_sel_in[0]) begin
        delay_buzzer_control_ff <= wb_dat_in[3:0];
      end
    end
  end

  // ack for one cycle per request, dropped the cycle after
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      dat_ff <= req ? nxt_dat : dat_ff;
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = dat_ff;

  // ----------------------------------------------------------------
  // bidirectional and input-only ports
  // ----------------------------------------------------------------
  // reset leaves direction and pull-ups clear, so every driver is released
  assign bidir_pin_out = p8_out_ff;
  assign bidir_pin_oe_n_out = ~port_eight_direction_ff;
  assign bidir_pullup_out = port_eight_pullup_ff;
  assign input_pull_en_out = input_port_pull_select_ff[7:0];
  assign input_pull_down_out = input_port_pull_select_ff[ppfs_pkg::PA_POL_BIT];

  // ----------------------------------------------------------------
  // port 0: serial channels and buzzer
  // ----------------------------------------------------------------
  wire [6:0] d0 = port_zero_direction_ff[6:0];
  wire [3:0] sm0 = serial0_mode_reg3_ff;
  wire [3:0] sm1 = serial1_mode_reg1_ff;

  wire s0_dout = d0[ppfs_pkg::P0_SER0_DOUT] & sm0[ppfs_pkg::SER_DOUT_BIT];
  wire s1_dout = d0[ppfs_pkg::P0_SER1_DOUT] & sm1[ppfs_pkg::SER_DOUT_BIT];
  wire s0_din = ~d0[ppfs_pkg::P0_SER0_DIN] & sm0[ppfs_pkg::SER_DIN_BIT];
  wire s1_din = ~d0[ppfs_pkg::P0_SER1_DIN] & sm1[ppfs_pkg::SER_DIN_BIT];
  // clock master only when the mode asks for it and the bit is an output
  wire s0_clko = d0[ppfs_pkg::P0_SER0_CLK] & sm0[ppfs_pkg::SER_CLKO_BIT];
  wire s1_clko = d0[ppfs_pkg::P0_SER1_CLK] & sm1[ppfs_pkg::SER_CLKO_BIT];
  wire s0_clki = ~d0[ppfs_pkg::P0_SER0_CLK] & ~sm0[ppfs_pkg::SER_CLKO_BIT] & (|sm0[1:0]);
  wire s1_clki = ~d0[ppfs_pkg::P0_SER1_CLK] & ~sm1[ppfs_pkg::SER_CLKO_BIT] & (|sm1[1:0]);
  wire buz_sel = d0[ppfs_pkg::P0_BUZZER] & delay_buzzer_control_ff[ppfs_pkg::BUZ_EN_BIT];

  // any function not selected falls back to the output latch
  wire [6:0] p0_val = {
    buz_sel ? buzzer_in : p0_out_ff[6],
    s1_clko ? ser1_clk_in : p0_out_ff[5],
    p0_out_ff[4],
    s1_dout ? ser1_tx_in : p0_out_ff[3],
    s0_clko ? ser0_clk_in : p0_out_ff[2],
    p0_out_ff[1],
    s0_dout ? ser0_tx_in : p0_out_ff[0]};

  // open drain releases the pin for a high; buzzer pin stays push-pull
  wire [6:0] p0_od = p0_open_drain_ff[6:0] & 7'h3f;
  assign port0_pin_out = p0_val;
  assign port0_pin_oe_n_out = ~(d0 & ~(p0_od & p0_val));
  assign port0_pullup_out = port_zero_pullup_ff[6:0];

  // receivers see an idle high when their pin is not routed to them
  assign ser0_rx_out = s0_din ? p0_pin[ppfs_pkg::P0_SER0_DIN] : 1'b1;
  assign ser1_rx_out = s1_din ? p0_pin[ppfs_pkg::P0_SER1_DIN] : 1'b1;
  assign ser0_clk_out = s0_clki ? p0_pin[ppfs_pkg::P0_SER0_CLK] : 1'b1;
  assign ser1_clk_out = s1_clki ? p0_pin[ppfs_pkg::P0_SER1_CLK] : 1'b1;
  assign ser0_uart_mode_out = sm0[ppfs_pkg::SER_UART_BIT];
  assign buzzer_freq_out = delay_buzzer_control_ff[ppfs_pkg::BUZ_FREQ_LSB +: ppfs_pkg::BUZ_FREQ_W];

  // ----------------------------------------------------------------
  // port 1: carrier and timers
  // ----------------------------------------------------------------
  wire [7:0] d1 = port_one_direction_ff;
  wire [7:0] omd = port_one_output_select_ff;
  wire car_sel = omd[ppfs_pkg::P1_CARRIER] & d1[ppfs_pkg::P1_CARRIER] & carrier_output_control_ff;
  wire t2_sel = omd[ppfs_pkg::P1_TIMER2] & d1[ppfs_pkg::P1_TIMER2];
  wire t3_sel = omd[ppfs_pkg::P1_TIMER3] & d1[ppfs_pkg::P1_TIMER3];

  logic [7:0] p1_val;
  always_comb begin
    p1_val = p1_out_ff;
    p1_val[ppfs_pkg::P1_CARRIER] = car_sel ? carrier_in : p1_out_ff[ppfs_pkg::P1_CARRIER];
    p1_val[ppfs_pkg::P1_TIMER2] = t2_sel ? timer2_out_in : p1_out_ff[ppfs_pkg::P1_TIMER2];
    p1_val[ppfs_pkg::P1_TIMER3] = t3_sel ? timer3_out_in : p1_out_ff[ppfs_pkg::P1_TIMER3];
  end

  assign port1_pin_out = p1_val;
  assign port1_pin_oe_n_out = ~d1;
  assign port1_pullup_out = port_one_pullup_ff;
  // event clock only in input mode; held low otherwise so no stray counts
  assign timer2_evt_out = ~d1[ppfs_pkg::P1_TIMER2] & p1_pin[ppfs_pkg::P1_TIMER2];
  assign timer3_evt_out = ~d1[ppfs_pkg::P1_TIMER3] & p1_pin[ppfs_pkg::P1_TIMER3];
  assign carrier_en_out = carrier_output_control_ff;
endmodule : ppfs_top

/* core/ppfs_pkg.sv */
// package: register map, field positions, reset values for port pin function select
package ppfs_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BIDIR_W = 8;
  localparam int unsigned INPUT_W = 8;
  localparam int unsigned PORT0_W = 7;
  localparam int unsigned PORT1_W = 8;
  localparam int unsigned SYNC_W = BIDIR_W + INPUT_W + PORT0_W + PORT1_W;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_P8_OUT = 8'h00;
  localparam logic [7:0] OFS_P8_DIR = 8'h04;
  localparam logic [7:0] OFS_P8_PLU = 8'h08;
  localparam logic [7:0] OFS_P8_PIN = 8'h0c;
  localparam logic [7:0] OFS_PA_PULL = 8'h10;
  localparam logic [7:0] OFS_PA_PIN = 8'h14;
  localparam logic [7:0] OFS_P0_OUT = 8'h18;
  localparam logic [7:0] OFS_P0_DIR = 8'h1c;
  localparam logic [7:0] OFS_P0_PLU = 8'h20;
  localparam logic [7:0] OFS_P0_ODR = 8'h24;
  localparam logic [7:0] OFS_P0_PIN = 8'h28;
  localparam logic [7:0] OFS_P1_OUT = 8'h2c;
  localparam logic [7:0] OFS_P1_DIR = 8'h30;
  localparam logic [7:0] OFS_P1_PLU = 8'h34;
  localparam logic [7:0] OFS_P1_OMD = 8'h38;
  localparam logic [7:0] OFS_P1_PIN = 8'h3c;
  localparam logic [7:0] OFS_SER0_MD3 = 8'h40;
  localparam logic [7:0] OFS_SER1_MD1 = 8'h44;
  localparam logic [7:0] OFS_CARRIER = 8'h48;
  localparam logic [7:0] OFS_BUZZER = 8'h4c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned PA_POL_BIT = 8;
  localparam int unsigned SER_DOUT_BIT = 0;
  localparam int unsigned SER_DIN_BIT = 1;
  localparam int unsigned SER_CLKO_BIT = 2;
  localparam int unsigned SER_UART_BIT = 3;
  localparam int unsigned CAR_EN_BIT = 0;
  localparam int unsigned BUZ_EN_BIT = 0;
  localparam int unsigned BUZ_FREQ_LSB = 1;
  localparam int unsigned BUZ_FREQ_W = 3;
  // port bit positions of shared functions
  localparam int unsigned P0_SER0_DOUT = 0;
  localparam int unsigned P0_SER0_DIN = 1;
  localparam int unsigned P0_SER0_CLK = 2;
  localparam int unsigned P0_SER1_DOUT = 3;
  localparam int unsigned P0_SER1_DIN = 4;
  localparam int unsigned P0_SER1_CLK = 5;
  localparam int unsigned P0_BUZZER = 6;
  localparam int unsigned P1_CARRIER = 0;
  localparam int unsigned P1_TIMER2 = 2;
  localparam int unsigned P1_TIMER3 = 3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [8:0] RST_PA_PULL = 9'h000;
  localparam logic [3:0] RST_SER = 4'h0;
  localparam logic [3:0] RST_BUZ = 4'h0;
endpackage : ppfs_pkg

/* core/ppfs_sync_if.sv */
// interface: raw pin levels in, filtered levels out of the pin synchroniser
`timescale 1ns/1ps
interface ppfs_sync_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : ppfs_sync_if

/* core/ppfs_pin_sync.sv */
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ppfs_pin_sync #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // pin levels
  ppfs_sync_if.filt sync_io
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] clean_ff;
  wire [W-1:0] agree;
  wire [W-1:0] nxt_clean;

  // ----------------------------------------------------------------
  // agreement filter
  // ----------------------------------------------------------------
  // s1 is read only by s2, so metastability never reaches the filter
  assign agree = ~(s2_ff ^ s3_ff);
  assign nxt_clean = (agree & s3_ff) | (~agree & clean_ff);
  assign sync_io.clean = clean_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      clean_ff <= '0;
    end else begin
      s1_ff <= sync_io.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      clean_ff <= nxt_clean;
    end
  end
endmodule : ppfs_pin_sync

/* tb/ppfs_pin_model.sv */
// model: external circuit on one group of port pins
`timescale 1ns/1ps
module ppfs_pin_model #(
  parameter int W = 8
) (
  // device side
  input wire logic [W-1:0] pin_out_in,
  input wire logic [W-1:0] oe_n_in,
  input wire logic [W-1:0] pullup_in,
  // circuit side
  input wire logic [W-1:0] ext_en_in,
  input wire logic [W-1:0] ext_val_in,
  output logic [W-1:0] level_out
);
  // a floating pin shows high with its pull-up on, else the inverse of the device value, so no stale level passes
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_out[i] = !oe_n_in[i] ? pin_out_in[i] : ext_en_in[i] ? ext_val_in[i] : pullup_in[i] | !pin_out_in[i];
    end
  end
endmodule : ppfs_pin_model

/* tb/ppfs_monitor.sv */
// checker: bus and pin relations at the ports of ppfs_top
`timescale 1ns/1ps
module ppfs_monitor (
  // clock, reset and bus
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic wb_ack_out,
  // pin side
  input wire logic [7:0] bidir_pin_oe_n_out,
  input wire logic [7:0] bidir_pullup_out,
  input wire logic [7:0] input_pull_en_out,
  input wire logic [6:0] port0_pin_oe_n_out,
  input wire logic ser0_rx_out,
  input wire logic ser0_uart_mode_out
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire wr = take && wb_we_in;
  sequence s_req; take; endsequence
  sequence s_ack; wb_ack_out ##1 !wb_ack_out; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
  property p_rst; $rose(nrst_in) |-> bidir_pin_oe_n_out == 8'hff && bidir_pullup_out == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("bidir port not released after reset");
  property p_rst_pa; $rose(nrst_in) |-> input_pull_en_out == 8'h00; endproperty
  a_rst_pa: assert property (p_rst_pa) else $error("input pulls on after reset");
  property p_dir; $changed(bidir_pin_oe_n_out) |-> $past(wr && wb_adr_in == ppfs_pkg::OFS_P8_DIR); endproperty
  a_dir: assert property (p_dir) else $error("direction changed without write");
  property p_plu; $changed(bidir_pullup_out) |-> $past(wr && wb_adr_in == ppfs_pkg::OFS_P8_PLU); endproperty
  a_plu: assert property (p_plu) else $error("pull-up changed without write");
  property p_pull; $changed(input_pull_en_out) |-> $past(wr && wb_adr_in == ppfs_pkg::OFS_PA_PULL); endproperty
  a_pull: assert property (p_pull) else $error("input pull changed without write");
  property p_rx; !ser0_rx_out |-> port0_pin_oe_n_out[1]; endproperty
  a_rx: assert property (p_rx) else $error("receive fed from driven pin");
  property p_uart; $changed(ser0_uart_mode_out) |-> $past(wr && wb_adr_in == ppfs_pkg::OFS_SER0_MD3); endproperty
  a_uart: assert property (p_uart) else $error("uart flag changed without write");
endmodule : ppfs_monitor
bind ppfs_top ppfs_monitor ppfs_monitor_i (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_ack_out(wb_ack_out),
  .bidir_pin_oe_n_out(bidir_pin_oe_n_out), .bidir_pullup_out(bidir_pullup_out),
  .input_pull_en_out(input_pull_en_out), .port0_pin_oe_n_out(port0_pin_oe_n_out),
  .ser0_rx_out(ser0_rx_out), .ser0_uart_mode_out(ser0_uart_mode_out));

/* tb/ppfs_top_tb.sv */
// testbench: register access and pin routing of ppfs_top
`timescale 1ns/1ps
module ppfs_top_tb;
  logic clk_in = 1'b0, nrst_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00, input_pin_in = 8'h00, e8 = 8'h00, v8 = 8'h00, e1 = 8'h00, v1 = 8'h00;
  logic [7:0] eng = 8'h00;
  logic [6:0] e0 = 7'h00, v0 = 7'h00;
  logic [3:0] wb_sel_in = 4'hf;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
  logic wb_ack_out, input_pull_down_out, ser0_rx_out, ser0_clk_out, ser0_uart_mode_out, ser1_rx_out;
  logic ser1_clk_out, timer2_evt_out, timer3_evt_out, carrier_en_out;
  logic [2:0] buzzer_freq_out;
  logic [7:0] bidir_pin_in, bidir_pin_out, bidir_pin_oe_n_out, bidir_pullup_out, input_pull_en_out;
  logic [7:0] port1_pin_in, port1_pin_out, port1_pin_oe_n_out, port1_pullup_out;
  logic [6:0] port0_pin_in, port0_pin_out, port0_pin_oe_n_out, port0_pullup_out;
  wire ser0_tx_in = eng[0], ser0_clk_in = eng[1], ser1_tx_in = eng[2], ser1_clk_in = eng[3];
  wire timer2_out_in = eng[4], timer3_out_in = eng[5], carrier_in = eng[6], buzzer_in = eng[7];
  int fail_count = 0, n_tests = 0;
  ppfs_top ppfs_top_i (.*);
  ppfs_pin_model #(.W(8)) m8_i (.pin_out_in(bidir_pin_out), .oe_n_in(bidir_pin_oe_n_out),
    .pullup_in(bidir_pullup_out), .ext_en_in(e8), .ext_val_in(v8), .level_out(bidir_pin_in));
  ppfs_pin_model #(.W(7)) m0_i (.pin_out_in(port0_pin_out), .oe_n_in(port0_pin_oe_n_out),
    .pullup_in(port0_pullup_out), .ext_en_in(e0), .ext_val_in(v0), .level_out(port0_pin_in));
  ppfs_pin_model #(.W(8)) m1_i (.pin_out_in(port1_pin_out), .oe_n_in(port1_pin_oe_n_out),
    .pullup_in(port1_pullup_out), .ext_en_in(e1), .ext_val_in(v1), .level_out(port1_pin_in));
  initial forever #2 clk_in = ~clk_in;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tk
  // one classic cycle; the leading edge keeps cyc low for a cycle between transfers
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      $display("[FAIL] %0t no bus answer", $time);
      stop_test();
    end
  endtask : wb
  initial begin
    tk(16);
    nrst_in <= 1'b1;
    wb(1'b0, ppfs_pkg::OFS_P8_DIR, 32'h0); chk(q, 32'h0);
    chk(32'({bidir_pin_oe_n_out, bidir_pullup_out}), 32'hff00);
    wb(1'b0, ppfs_pkg::OFS_PA_PULL, 32'h0); chk(q | 32'(input_pull_en_out), 32'h0);
    wb(1'b1, ppfs_pkg::OFS_P8_OUT, 32'ha5);
    wb(1'b1, ppfs_pkg::OFS_P8_DIR, 32'h0f);
    e8 <= 8'hf0;
    v8 <= 8'hc0;
    input_pin_in <= 8'h3c;
    chk(32'(bidir_pin_oe_n_out), 32'hf0);
    chk(32'(bidir_pin_out & 8'h0f), 32'h05);
    tk(5);
    wb(1'b0, ppfs_pkg::OFS_P8_PIN, 32'h0); chk(q, 32'hc5);
    wb(1'b0, ppfs_pkg::OFS_PA_PIN, 32'h0); chk(q, 32'h3c);
    wb(1'b1, ppfs_pkg::OFS_P8_PLU, 32'h3c); chk(32'(bidir_pullup_out), 32'h3c);
    wb(1'b1, ppfs_pkg::OFS_PA_PULL, 32'h181); chk(32'({input_pull_down_out, input_pull_en_out}), 32'h181);
    wb(1'b0, ppfs_pkg::OFS_PA_PULL, 32'h0); chk(q, 32'h181);
    wb(1'b1, ppfs_pkg::OFS_P0_DIR, 32'h01);
    wb(1'b1, ppfs_pkg::OFS_SER0_MD3, 32'h0b);
    e0 <= 7'h06;
    v0 <= 7'h00;
    eng <= 8'h01;
    tk(5);
    chk(32'({port0_pin_oe_n_out[0], port0_pin_out[0]}), 32'h1);
    chk(32'({ser0_uart_mode_out, ser0_rx_out, ser0_clk_out}), 32'h4);
    wb(1'b1, ppfs_pkg::OFS_P0_ODR, 32'h01); chk(32'(port0_pin_oe_n_out[0]), 32'h1);
    wb(1'b1, ppfs_pkg::OFS_SER0_MD3, 32'h0); chk(32'(ser0_rx_out), 32'h1);
    wb(1'b0, ppfs_pkg::OFS_P0_PIN, 32'h0); chk(q, 32'h78);
    wb(1'b1, ppfs_pkg::OFS_P0_PLU, 32'h12); chk(32'(port0_pullup_out), 32'h12);
    wb(1'b1, ppfs_pkg::OFS_P0_DIR, 32'h21);
    wb(1'b1, ppfs_pkg::OFS_SER1_MD1, 32'h04);
    eng <= 8'h08;
    tk(1); chk(32'({port0_pin_out[5], ser1_clk_out, ser1_rx_out}), 32'h7);
    wb(1'b1, ppfs_pkg::OFS_P1_OMD, 32'h05);
    wb(1'b1, ppfs_pkg::OFS_P1_DIR, 32'h05);
    wb(1'b1, ppfs_pkg::OFS_P1_PLU, 32'h08); chk(32'(port1_pullup_out), 32'h08);
    e1 <= 8'h08;
    v1 <= 8'h08;
    eng <= 8'h50;
    tk(5);
    chk(32'({port1_pin_out[2], timer3_evt_out, timer2_evt_out}), 32'h6);
    chk(32'(port1_pin_out[0]), 32'h0);
    wb(1'b1, ppfs_pkg::OFS_CARRIER, 32'h1); chk(32'({carrier_en_out, port1_pin_out[0]}), 32'h3);
    wb(1'b1, ppfs_pkg::OFS_P0_DIR, 32'h61);
    wb(1'b1, ppfs_pkg::OFS_BUZZER, 32'h0b);
    eng <= 8'h80;
    tk(1); chk(32'({buzzer_freq_out, port0_pin_out[6]}), 32'hb);
    wb(1'b0, 8'hfc, 32'h0); chk(q, 32'h0);
    stop_test();
  end
endmodule : ppfs_top_tb
